//--- hdl/compare_b_pkg.sv
package compare_b_pkg;

  // register word offsets (byte addresses on the bus)
  localparam logic [3:0]  value_offset   = 4'h0;
  localparam logic [3:0]  control_offset = 4'h4;
  localparam logic [3:0]  qualifier_offset = 4'h8;

  // compare_control field positions
  localparam int          load_select_lsb      = 2;
  localparam int          shadow_disable_bit   = 6;
  localparam int          shadow_pending_bit   = 9;

  // qualifier control field position for compare-b-up action
  localparam int          qual_b_event_lsb     = 8;

  // reset values
  localparam logic [15:0] value_reset          = 16'h0000;
  localparam logic [1:0]  load_select_reset    = 2'h0;
  localparam logic        shadow_disable_reset = 1'b0;
  localparam logic [1:0]  action_reset         = 2'h0;

  typedef enum logic [1:0] {
    load_at_zero   = 2'h0,
    load_at_period = 2'h1,
    load_at_either = 2'h2,
    load_frozen    = 2'h3
  } load_select_type;

  typedef enum logic [1:0] {
    action_none   = 2'h0,
    action_clear  = 2'h1,
    action_set    = 2'h2,
    action_toggle = 2'h3
  } action_type;

  typedef struct packed {
    logic [3:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } wb_request_type;

  typedef struct packed {
    logic        zero;
    logic        period;
    logic [15:0] count;
  } timebase_type;

endpackage : compare_b_pkg

//--- hdl/compare_b_qualifier.sv
`timescale 1ns/1ps
module compare_b_qualifier
  import compare_b_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // event and per-output actions
  input  wire logic       compare_event,
  input  wire action_type action_a,
  input  wire action_type action_b,
  // outputs
  output logic            pwm_output_a,
  output logic            pwm_output_b
);

  typedef struct packed {
    logic a;
    logic b;
  } qual_state_type;

  qual_state_type state;
  qual_state_type next_state;

  function automatic logic apply_action(input action_type act, input logic level);
    unique case (act)
      action_none:   apply_action = level;
      action_clear:  apply_action = 1'b0;
      action_set:    apply_action = 1'b1;
      action_toggle: apply_action = ~level;
    endcase
  endfunction : apply_action

  always_comb begin
    next_state = state;
    if (compare_event) begin
      next_state.a = apply_action(action_a, state.a);
      next_state.b = apply_action(action_b, state.b);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pwm_output_a = state.a;
  assign pwm_output_b = state.b;

endmodule : compare_b_qualifier

//--- hdl/counter_compare_b_channel.sv
// Overview of operation
// - active value compared with timebase count every cycle; equal raises event
// - equality event is delivered to the action stage for both outputs
// - per output action: ignore, drive low, drive high, or invert
// - buffered mode after reset; control bit selects buffered or direct
// - shadow disable 0: reads and writes of value address reach shadow
// - buffered: shadow copied to active only on selected counter event
// - readable pending bit tells whether shadow holds an unloaded value
// - shadow disable 1: reads and writes reach the active value directly
// - both copies share one address; routing set only by shadow disable
// - load select: 00 zero, 01 period, 10 either, 11 no loads
// - pending bit clears itself on a shadow to active load
// - write while pending overwrites waiting shadow value, no queue
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module counter_compare_b_channel
  import compare_b_pkg::*;
#(
  parameter int value_width = 16
)
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // wishbone slave
  input  wire logic [3:0]             wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic                   wb_we_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  // shared time-base
  input  wire logic [value_width-1:0] timebase_count,
  input  wire logic                   timebase_zero,
  input  wire logic                   timebase_period,
  // event and outputs
  output logic                        compare_b_event,
  output logic                        pwm_output_a,
  output logic                        pwm_output_b
);

  typedef struct packed {
    logic [value_width-1:0] active;
    logic [value_width-1:0] shadow;
    logic                   shadow_pending;
    logic                   shadow_disable;
    load_select_type        load_select;
    action_type             qualifier_control_out_a;
    action_type             qualifier_control_out_b;
    logic                   ack;
    logic [31:0]            rdata;
  } chan_state_type;

  chan_state_type state;
  chan_state_type next_state;
  wb_request_type req;
  timebase_type   tb;

  logic           access;
  logic           load_strobe;
  logic           write_value;
  logic           match;

  function automatic logic load_point(input load_select_type sel, input logic zero, input logic period);
    unique case (sel)
      load_at_zero:   load_point = zero;
      load_at_period: load_point = period;
      load_at_either: load_point = zero | period;
      load_frozen:    load_point = 1'b0;
    endcase
  endfunction : load_point

  always_comb begin
    req.adr = wb_adr_i;
    req.dat = wb_dat_i;
    req.sel = wb_sel_i;
    req.we  = wb_we_i;
    req.cyc = wb_cyc_i;
    req.stb = wb_stb_i;
    tb.count  = timebase_count;
    tb.zero   = timebase_zero;
    tb.period = timebase_period;
  end

  // one wait state per access; ack drops the cycle after it was given
  assign access      = req.cyc & req.stb & ~state.ack;
  assign write_value = access & req.we & (req.adr == value_offset);
  assign load_strobe = ~state.shadow_disable
                       & load_point(state.load_select, tb.zero, tb.period);
  assign match       = (state.active == tb.count);

  always_comb begin
    next_state       = state;
    next_state.ack   = access;
    next_state.rdata = 32'h0000_0000;

    if (load_strobe) begin
      next_state.active         = state.shadow;
      next_state.shadow_pending = 1'b0;
    end

    if (write_value) begin
      if (state.shadow_disable) begin
        if (req.sel[0]) next_state.active[7:0]  = req.dat[7:0];
        if (req.sel[1]) next_state.active[15:8] = req.dat[15:8];
      end else begin
        // a write overwrites the pending shadow and beats a same-cycle load clear
        if (req.sel[0]) next_state.shadow[7:0]  = req.dat[7:0];
        if (req.sel[1]) next_state.shadow[15:8] = req.dat[15:8];
        next_state.shadow_pending = 1'b1;
      end
    end

    if (access && req.we && req.adr == control_offset) begin
      if (req.sel[0]) begin
        next_state.shadow_disable = req.dat[shadow_disable_bit];
        next_state.load_select    = load_select_type'(req.dat[load_select_lsb +: 2]);
      end
    end

    if (access && req.we && req.adr == qualifier_offset) begin
      if (req.sel[1]) begin
        next_state.qualifier_control_out_a = action_type'(req.dat[qual_b_event_lsb +: 2]);
        next_state.qualifier_control_out_b = action_type'(req.dat[qual_b_event_lsb + 2 +: 2]);
      end
    end

    if (access && !req.we) begin
      unique case (req.adr)
        value_offset: begin
          next_state.rdata[15:0] = 16'(state.shadow_disable ? state.active : state.shadow);
        end
        control_offset: begin
          next_state.rdata[shadow_pending_bit]     = state.shadow_pending;
          next_state.rdata[shadow_disable_bit]     = state.shadow_disable;
          next_state.rdata[load_select_lsb +: 2]   = state.load_select;
        end
        qualifier_offset: begin
          next_state.rdata[qual_b_event_lsb +: 2]     = state.qualifier_control_out_a;
          next_state.rdata[qual_b_event_lsb + 2 +: 2] = state.qualifier_control_out_b;
        end
        default: begin
          next_state.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state.active                  <= value_reset;
      state.shadow                  <= value_reset;
      state.shadow_pending          <= 1'b0;
      state.shadow_disable          <= shadow_disable_reset;
      state.load_select             <= load_at_zero;
      state.qualifier_control_out_a <= action_none;
      state.qualifier_control_out_b <= action_none;
      state.ack                     <= 1'b0;
      state.rdata                   <= 32'h0000_0000;
    end else begin
      state <= next_state;
    end
  end

  assign wb_ack_o        = state.ack;
  assign wb_dat_o        = state.rdata;
  // combinational so it lands in the very cycle of the match
  assign compare_b_event = match;

  compare_b_qualifier qualifier (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .compare_event (compare_b_event),
    .action_a      (state.qualifier_control_out_a),
    .action_b      (state.qualifier_control_out_b),
    .pwm_output_a  (pwm_output_a),
    .pwm_output_b  (pwm_output_b)
  );

endmodule : counter_compare_b_channel

//--- verif/timebase_model.sv
`timescale 1ns/1ps
module timebase_model
#(
  parameter logic [15:0] period_count = 16'h0010
)
(
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  reset,
  // shared counter
  output logic [15:0] count,
  output logic        zero,
  output logic        period
);
  always_ff @(posedge sys_clk) begin
    if (reset || count == period_count) count <= 16'h0000;
    else count <= count + 16'h0001;
  end
  assign zero   = (count == 16'h0000);
  assign period = (count == period_count);
endmodule : timebase_model

//--- verif/counter_compare_b_channel_chk.sv
`timescale 1ns/1ps
module counter_compare_b_channel_chk
  import compare_b_pkg::*;
#(
  parameter int value_width = 16
)
(
  // clock, reset, bus
  input wire logic                   sys_clk,
  input wire logic                   reset,
  input wire logic [3:0]             wb_adr_i,
  input wire logic                   wb_we_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  // time-base and outputs
  input wire logic [value_width-1:0] timebase_count,
  input wire logic                   compare_b_event,
  input wire logic                   pwm_output_a,
  input wire logic                   pwm_output_b
);
  default clocking cb @(posedge sys_clk); endclocking
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic rd  = wb_ack_o && !wb_we_i;
  a_ack_pulse: assert property (disable iff (reset) wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_latency: assert property (disable iff (reset) req && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_no_stray: assert property (disable iff (reset) !req |=> !wb_ack_o) else $error("stray ack");
  a_idle_data: assert property (disable iff (reset) !wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  a_ctrl_reserved: assert property (disable iff (reset) rd && wb_adr_i == control_offset
    |-> (wb_dat_o & ~32'h0000024c) == 32'h0) else $error("control spare bits");
  a_event_reset: assert property (reset ##1 reset |-> compare_b_event == (timebase_count == 0)) else $error("event");
  a_pwm_reset: assert property (reset |=> !pwm_output_a && !pwm_output_b) else $error("pwm reset");
  a_pwm_hold: assert property (disable iff (reset) !compare_b_event
    |=> $stable({pwm_output_a, pwm_output_b})) else $error("pwm moved");
  a_event_pulse: assert property (disable iff (reset) compare_b_event && !req
    ##1 !$stable(timebase_count) && !req |-> !compare_b_event) else $error("event long");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_event: cover property (compare_b_event);
  c_pwm: cover property ($rose(pwm_output_a));
endmodule : counter_compare_b_channel_chk

bind counter_compare_b_channel counter_compare_b_channel_chk #(.value_width(value_width)) chk_u (
  .sys_clk(sys_clk), .reset(reset), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timebase_count(timebase_count),
  .compare_b_event(compare_b_event), .pwm_output_a(pwm_output_a), .pwm_output_b(pwm_output_b));

//--- verif/counter_compare_b_channel_tb.sv
`timescale 1ns/1ps
`define CHK(w, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h got %h", w, e, g); end end
module counter_compare_b_channel_tb
  import compare_b_pkg::*;
;
  logic           sys_clk = 1'b0;
  logic           reset   = 1'b1;
  wb_request_type wb      = '0;
  logic [31:0]    dat_o;
  logic           ack, ev, pa, pb, tz, tp;
  logic [15:0]    tc;
  int             err_count = 0;
  int             n_tests   = 0;
  initial forever #50 sys_clk = ~sys_clk;
  timebase_model tb_u (.sys_clk(sys_clk), .reset(reset), .count(tc), .zero(tz), .period(tp));
  counter_compare_b_channel dut_u (.sys_clk(sys_clk), .reset(reset), .wb_adr_i(wb.adr), .wb_dat_i(wb.dat),
    .wb_sel_i(wb.sel), .wb_we_i(wb.we), .wb_cyc_i(wb.cyc), .wb_stb_i(wb.stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .timebase_count(tc), .timebase_zero(tz), .timebase_period(tp), .compare_b_event(ev),
    .pwm_output_a(pa), .pwm_output_b(pb));
  task automatic complete_run;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int i;
    wb <= '{adr: a, dat: d, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge sys_clk);
    if (i == 20) begin
      err_count++;
      complete_run();
    end
    r = dat_o;
    wb <= '0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic rd_chk(input string w, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    `CHK(w, e, r)
  endtask : rd_chk
  task automatic wait_count(input logic [15:0] c);
    for (int i = 0; i < 40 && tc !== c; i++) @(posedge sys_clk);
    `CHK("count reached", c, tc)
  endtask : wait_count
  task automatic t_reset;
    rd_chk("control reset", control_offset, 32'h0);
    rd_chk("value reset", value_offset, 32'h0);
    rd_chk("unmapped", 4'hc, 32'h0);
    $display("reset done");
  endtask : t_reset
  task automatic t_loads;
    logic [31:0] v;
    for (int k = 0; k < 4; k++) begin
      v = 32'h00a0 + k;
      wr(control_offset, 32'h40);
      wr(value_offset, 32'h0050);
      wr(control_offset, k << 2);
      wait_count(16'h0001);
      wr(value_offset, 32'h00ff);
      wr(value_offset, v);
      rd_chk("pending", control_offset, 32'h200 | (k << 2));
      rd_chk("shadow", value_offset, v);
      // read taken at count zero: a period load has already cleared pending, a zero load not yet
      wait_count(16'h0010);
      rd_chk("pending at zero", control_offset, ((k == 0 || k == 3) ? 32'h200 : 32'h0) | (k << 2));
      rd_chk("loaded", control_offset, (k == 3 ? 32'h200 : 32'h0) | (k << 2));
      wr(control_offset, 32'h40);
      rd_chk("active", value_offset, k == 3 ? 32'h50 : v);
    end
    $display("loads done");
  endtask : t_loads
  task automatic t_event;
    wr(qualifier_offset, 32'h0e00);
    wr(value_offset, 32'h0005);
    for (int i = 0; i < 40 && ev !== 1'b1; i++) @(posedge sys_clk);
    `CHK("event count", 16'h0005, tc)
    @(posedge sys_clk);
    `CHK("event pulse", 1'b0, ev)
    `CHK("pwm a", 1'b1, pa)
    `CHK("pwm b", 1'b1, pb)
    rd_chk("direct", value_offset, 32'h0005);
    $display("event done");
  endtask : t_event
  initial begin
    #5000000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_loads();
    t_event();
    complete_run();
  end
endmodule : counter_compare_b_channel_tb
